// ==== hw/can_xcvr_pkg.sv ====
// package: constants and carriers for the can transceiver control block
package can_xcvr_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS        = 4000;
    localparam int TIMEOUT_NOM_US       = 2000;
    localparam int TIMEOUT_MIN_US       = 500;
    localparam int TIMEOUT_MAX_US       = 4000;
    localparam int ENABLE_TIME_US       = 40;
    localparam int TIMEOUT_CYCLES       = TIMEOUT_NOM_US * 1000000 / CLK_PERIOD_PS;
    localparam int TIMEOUT_MIN_CYCLES   = (TIMEOUT_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // wide product: the picosecond figure of the longest timeout overflows 32 bits
    localparam int TIMEOUT_MAX_CYCLES   = int'(longint'(TIMEOUT_MAX_US) * 1000000 / CLK_PERIOD_PS);
    localparam int ENABLE_CYCLES        = (ENABLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W                = 24;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic canh_out;
        logic canh_oe;
        logic canl_out;
        logic canl_oe;
    } bus_drive_t;

    typedef struct packed {
        logic rxd_out;
        logic rxd_oe;
        logic rx_load_on;
    } rx_side_t;

    typedef enum logic [1:0] {
        TX_OFF,
        TX_ARMING,
        TX_TIMED_OUT,
        TX_READY
    } tx_state_t;

endpackage : can_xcvr_pkg

// ==== hw/sat_counter.sv ====
// file: saturating up-counter with clear and terminal flag
`timescale 1ns/10ps
module sat_counter #(
    parameter int W        = 24,
    parameter int TERMINAL = 16
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // control
    input  wire logic clear,
    input  wire logic run,
    // status
    output logic      done
);

    logic [W-1:0] cnt_r;

    always_ff @(posedge clock)
    begin
        if (!reset_n || clear)
            cnt_r <= '0;
        else if (run && cnt_r != W'(TERMINAL))
            cnt_r <= cnt_r + 1'b1;
    end

    assign done = (cnt_r == W'(TERMINAL));

endmodule : sat_counter

// ==== hw/can_tx_ctrl.sv ====
// file: can transceiver digital control with transmit dominant timeout
// Functional notes
// RQ1 - enabled with transmit low drives the bus dominant, canh high and canl low, bounded by the timeout.
// RQ2 - enabled with transmit high leaves both bus drivers released so the bus is recessive.
// RQ3 - shutdown high releases both drivers and the receive output, ignores transmit and drops the input load.
// RQ4 - when active the receive output is low on a dominant bus and follows the bus otherwise, own traffic included.
// RQ5 - transmit input is active low and an undriven input reads high as recessive.
// RQ6 - a dominant timeout timer of nominal 2 ms starts when transmit goes low.
// RQ7 - if transmit stays low to expiry the driver returns to recessive though transmit is still low.
// RQ8 - transmit going high clears the timer so the next low drives dominant again.
// RQ9 - the controller keeps a bit rate of at least 22 kbps so eleven dominant bits end before 0.5 ms.
// RQ10 - for up to 4 Mbps the controller holds the shutdown input firmly low for fastest slew.
// RQ11 - after enable the driver starts timed out and stays recessive until a falling transmit edge after the enable time.
// RQ12 - overtemperature forces the driver recessive while the receiver keeps working.
// RQ13 - the timer is a counter whose terminal count lies inside the guaranteed timeout window.
`timescale 1ns/10ps
module can_tx_ctrl #(
    parameter int TIMEOUT_CYCLES = can_xcvr_pkg::TIMEOUT_CYCLES,
    parameter int ENABLE_CYCLES  = can_xcvr_pkg::ENABLE_CYCLES
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    // controller side
    input  wire logic                     transmit_data_in,
    input  wire logic                     transmit_data_oe,
    input  wire logic                     shutdown_slew_ctrl,
    output can_xcvr_pkg::rx_side_t        rx_side,
    // bus side
    input  wire logic                     bus_dominant,
    output can_xcvr_pkg::bus_drive_t      bus_drive,
    // protection
    input  wire logic                     over_temp
);

    // ---------------------------------------------------------------
    // input conditioning
    // ---------------------------------------------------------------
    logic txd_eff;
    logic txd_prev_r;
    logic txd_fall;
    logic enabled;

    // pull-up: an undriven pin reads recessive
    assign txd_eff  = transmit_data_oe ? transmit_data_in : 1'b1; // RQ5
    assign enabled  = !shutdown_slew_ctrl;
    assign txd_fall = txd_prev_r && !txd_eff;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            txd_prev_r <= 1'b1;
        else
            txd_prev_r <= txd_eff;
    end

    // ---------------------------------------------------------------
    // transmitter state
    // ---------------------------------------------------------------
    can_xcvr_pkg::tx_state_t state_r;
    can_xcvr_pkg::tx_state_t state_nxt;
    logic en_done;
    logic to_done;

    sat_counter #(
        .W        (can_xcvr_pkg::CNT_W),
        .TERMINAL (ENABLE_CYCLES)
    ) u_enable_cnt (
        .clock    (clock),
        .reset_n  (reset_n),
        .clear    (state_r != can_xcvr_pkg::TX_ARMING),
        .run      (1'b1),
        .done     (en_done)
    );

    // timer runs only while dominant is requested; high clears it
    sat_counter #(
        .W        (can_xcvr_pkg::CNT_W),
        .TERMINAL (TIMEOUT_CYCLES)
    ) u_timeout_cnt (
        .clock    (clock),
        .reset_n  (reset_n),
        .clear    (txd_eff || state_r != can_xcvr_pkg::TX_READY), // RQ8
        .run      (1'b1), // RQ6 RQ13
        .done     (to_done)
    );

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            can_xcvr_pkg::TX_OFF:
                if (enabled)
                    state_nxt = can_xcvr_pkg::TX_ARMING; // RQ11
            can_xcvr_pkg::TX_ARMING:
                if (en_done)
                    state_nxt = can_xcvr_pkg::TX_TIMED_OUT;
            can_xcvr_pkg::TX_TIMED_OUT:
                if (txd_fall)
                    state_nxt = can_xcvr_pkg::TX_READY; // RQ8 RQ11
            can_xcvr_pkg::TX_READY:
                if (to_done)
                    state_nxt = can_xcvr_pkg::TX_TIMED_OUT; // RQ7
            default:
                state_nxt = can_xcvr_pkg::TX_OFF;
        endcase
        if (!enabled)
            state_nxt = can_xcvr_pkg::TX_OFF; // RQ3
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            state_r <= can_xcvr_pkg::TX_OFF;
        else
            state_r <= state_nxt;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    logic dom_nxt;
    logic dom_r;
    logic rx_oe_r;
    logic rxd_r;

    // dom_nxt drops the cycle the counter hits terminal; the timed-out stretch ends one edge later
    assign dom_nxt = (state_nxt == can_xcvr_pkg::TX_READY) && !txd_eff && !over_temp; // RQ1 RQ2 RQ12

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            dom_r <= 1'b0;
        else
            dom_r <= dom_nxt;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            rx_oe_r <= 1'b0;
            rxd_r   <= 1'b1;
        end
        else
        begin
            rx_oe_r <= enabled; // RQ3
            rxd_r   <= !(bus_dominant || dom_r); // RQ4
        end
    end

    assign bus_drive.canh_out = dom_r;
    assign bus_drive.canh_oe  = dom_r;
    assign bus_drive.canl_out = 1'b0;
    assign bus_drive.canl_oe  = dom_r;
    assign rx_side.rxd_out    = rxd_r;
    assign rx_side.rxd_oe     = rx_oe_r;
    assign rx_side.rx_load_on = rx_oe_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // release registers one edge after terminal count, so a full stretch is one cycle longer
    localparam int CW = can_xcvr_pkg::CNT_W;
    logic [can_xcvr_pkg::CNT_W-1:0] dom_run_r;

    always_ff @(posedge clock)
    begin
        if (!reset_n || !dom_r)
            dom_run_r <= '0;
        else
            dom_run_r <= dom_run_r + 1'b1;
    end

    sequence s_shutdown;
        shutdown_slew_ctrl ##1 1'b1;
    endsequence

    a_dom_bounded: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
        dom_run_r <= CW'(TIMEOUT_CYCLES + 1))
        else $error("dominant held past timeout");
    a_recessive_high: assert property (@(posedge clock) disable iff (!reset_n) // RQ2
        txd_eff |=> !bus_drive.canh_oe && !bus_drive.canl_oe)
        else $error("driver active with transmit high");
    a_shutdown_quiet: assert property (@(posedge clock) disable iff (!reset_n) // RQ3
        s_shutdown |-> !bus_drive.canh_oe && !rx_side.rxd_oe && !rx_side.rx_load_on)
        else $error("outputs active in shutdown");
    a_rx_dominant: assert property (@(posedge clock) disable iff (!reset_n) // RQ4
        enabled && bus_dominant |=> !rx_side.rxd_out)
        else $error("receive not low on dominant bus");
    a_undriven_rec: assert property (@(posedge clock) disable iff (!reset_n) // RQ5
        !transmit_data_oe |=> !dom_r)
        else $error("undriven transmit gave dominant");
    a_expire_release: assert property (@(posedge clock) disable iff (!reset_n) // RQ7
        $rose(to_done) |=> !dom_r)
        else $error("no release at timeout");
    a_first_after_en: assert property (@(posedge clock) disable iff (!reset_n) // RQ11
        state_r == can_xcvr_pkg::TX_ARMING |=> !dom_r)
        else $error("dominant before enable time");
    a_overtemp_rec: assert property (@(posedge clock) disable iff (!reset_n) // RQ12
        over_temp |=> !dom_r)
        else $error("dominant during overtemperature");
    a_relow_redrive: assert property (@(posedge clock) disable iff (!reset_n) // RQ8
        state_r == can_xcvr_pkg::TX_TIMED_OUT && txd_fall && enabled && !over_temp |=> dom_r)
        else $error("no dominant after new low");

    // a high sample must leave the timer at zero, else the next low would expire early
    a_timer_clear: assert property (@(posedge clock) disable iff (!reset_n) // RQ8
        txd_eff |=> !to_done)
        else $error("timeout timer not cleared by high transmit");
    a_drive_levels: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
        bus_drive.canh_oe |-> bus_drive.canh_out && bus_drive.canl_oe && !bus_drive.canl_out)
        else $error("dominant drive levels wrong");
    a_off_recessive: assert property (@(posedge clock) disable iff (!reset_n) // RQ11
        state_r == can_xcvr_pkg::TX_OFF |=> !dom_r)
        else $error("dominant straight after enable");
    a_rx_recessive: assert property (@(posedge clock) disable iff (!reset_n) // RQ4
        enabled && !bus_dominant && !dom_r |=> rx_side.rxd_out)
        else $error("receive not high on recessive bus");
    a_rx_enabled: assert property (@(posedge clock) disable iff (!reset_n) // RQ3
        enabled |=> rx_side.rxd_oe && rx_side.rx_load_on)
        else $error("receive side released while enabled");

endmodule : can_tx_ctrl

// ==== tb/can_bus_model.sv ====
// bus model: wired-dominant can bus joining the block and other nodes
`timescale 1ns/10ps
module can_bus_model (
    // block driver
    input  wire can_xcvr_pkg::bus_drive_t bus_drive,
    // other nodes
    input  wire logic                     other_dom,
    // resolved bus
    output logic                          bus_dominant
);
    // dominant only while both lines are pulled apart, or another node pulls
    assign bus_dominant = (bus_drive.canh_oe & bus_drive.canh_out & bus_drive.canl_oe
                           & ~bus_drive.canl_out) | other_dom;
endmodule : can_bus_model

// ==== tb/can_tx_ctrl_dominant_timeout_tb_top.sv ====
// testbench: transceiver control with dominant timeout
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t mismatch", $time); end end
module can_tx_ctrl_dominant_timeout_tb_top;
    localparam int TO = 20;
    localparam int EN = 5;
    logic                     clock, reset_n, tx_in, tx_oe, shdn, other_dom, bus_dominant, over_temp;
    can_xcvr_pkg::rx_side_t   rx_side;
    can_xcvr_pkg::bus_drive_t bus_drive;
    int                       bad_count = 0;
    int                       tests_run = 0;

    can_tx_ctrl #(.TIMEOUT_CYCLES(TO), .ENABLE_CYCLES(EN)) can_tx_ctrl_i (.clock(clock), .reset_n(reset_n),
        .transmit_data_in(tx_in), .transmit_data_oe(tx_oe), .shutdown_slew_ctrl(shdn), .rx_side(rx_side),
        .bus_dominant(bus_dominant), .bus_drive(bus_drive), .over_temp(over_temp));
    can_bus_model can_bus_model_i (.bus_drive(bus_drive), .other_dom(other_dom), .bus_dominant(bus_dominant));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_enable;
        `CHK(rx_side.rxd_oe, 1'b0)
        `CHK(rx_side.rx_load_on, 1'b0)
        @(posedge clock) shdn <= 1'b0;
        step(EN + 4);
        `CHK(bus_drive.canh_oe, 1'b0)
        `CHK(rx_side.rxd_oe, 1'b1)
    endtask : t_enable

    task automatic t_dominant;
        @(posedge clock) tx_in <= 1'b1;
        step(2);
        @(posedge clock) tx_in <= 1'b0;
        step(3);
        `CHK(bus_drive, 4'hD)
        `CHK(rx_side.rxd_out, 1'b0)
        @(posedge clock) tx_in <= 1'b1;
        step(3);
        `CHK({bus_drive.canh_oe, bus_drive.canl_oe}, 2'h0)
        `CHK(rx_side.rxd_out, 1'b1)
        @(posedge clock) tx_in <= 1'b0;
        step(3);
        `CHK(bus_drive.canh_oe, 1'b1)
    endtask : t_dominant

    task automatic t_timeout;
        step(TO - 8);
        `CHK(bus_drive.canl_oe, 1'b1)
        step(15);
        `CHK({bus_drive.canh_oe, bus_drive.canl_oe}, 2'h0)
        @(posedge clock) tx_in <= 1'b1;
        step(2);
    endtask : t_timeout

    task automatic t_receive;
        @(posedge clock) other_dom <= 1'b1;
        step(3);
        `CHK(rx_side.rxd_out, 1'b0)
        @(posedge clock) other_dom <= 1'b0;
        step(3);
        `CHK(rx_side.rxd_out, 1'b1)
    endtask : t_receive

    task automatic t_undriven;
        @(posedge clock)
        begin
            tx_oe <= 1'b0;
            tx_in <= 1'b0;
        end
        step(4);
        `CHK(bus_drive.canh_oe, 1'b0)
        @(posedge clock)
        begin
            tx_oe <= 1'b1;
            tx_in <= 1'b1;
        end
        step(2);
    endtask : t_undriven

    task automatic t_overtemp;
        @(posedge clock) tx_in <= 1'b0;
        step(3);
        @(posedge clock)
        begin
            over_temp <= 1'b1;
            other_dom <= 1'b1;
        end
        step(3);
        `CHK(bus_drive.canh_oe, 1'b0)
        `CHK(rx_side.rxd_out, 1'b0)
        @(posedge clock)
        begin
            over_temp <= 1'b0;
            other_dom <= 1'b0;
            tx_in     <= 1'b1;
        end
        step(2);
    endtask : t_overtemp

    task automatic t_shutdown;
        @(posedge clock) tx_in <= 1'b0;
        step(3);
        `CHK(bus_drive.canh_oe, 1'b1)
        @(posedge clock) shdn <= 1'b1;
        step(3);
        `CHK({bus_drive.canh_oe, bus_drive.canl_oe, rx_side.rxd_oe, rx_side.rx_load_on}, 4'h0)
    endtask : t_shutdown

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        reset_n   = 1'b0;
        tx_in     = 1'b0;
        tx_oe     = 1'b1;
        shdn      = 1'b1;
        other_dom = 1'b0;
        over_temp = 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        step(2);
        t_enable();
        t_dominant();
        t_timeout();
        t_receive();
        t_undriven();
        t_overtemp();
        t_shutdown();
        complete_run();
    end

    initial
    begin
        // the whole sequence needs under 200 cycles
        #(4 * 2000);
        bad_count++;
        complete_run();
    end
endmodule : can_tx_ctrl_dominant_timeout_tb_top
